// File: logic/brf_bank_map.sv
// Bank mapping: which bank an operand or a control transfer lands in
`default_nettype none
module brf_bank_map (
  input wire logic priv_in,        // Privileged mode
  input wire logic bank_sel_in,    // Bank-select bit of the status word
  input wire logic [3:0] gen_num_in, // General operand number
  output logic is_banked_out,      // Number falls in registers zero to seven
  output logic active_bank_out,    // Bank ordinary operands see
  output logic inactive_bank_out,  // Bank the control transfers see
  output logic inactive_ok_out     // Inactive bank may be reached at all
);
  // User mode is pinned to bank zero whatever the select bit holds
  assign active_bank_out = priv_in & bank_sel_in;
  assign inactive_bank_out = ~active_bank_out;
  // Bank one copies are sealed off in user mode
  assign inactive_ok_out = priv_in;
  assign is_banked_out = ~gen_num_in[3];
endmodule // brf_bank_map
`default_nettype wire

// File: logic/brf_pkg.sv
// Package with widths, indices, reset values and selector codes for the banked register file
`default_nettype none
package brf_pkg;
  localparam int unsigned DATA_W = 32;        // Every register is one word
  localparam int unsigned GEN_IDX_W = 4;      // Sixteen general registers
  localparam int unsigned FLT_IDX_W = 4;      // Sixteen float registers
  localparam int unsigned BANK_IDX_W = 3;     // Eight banked registers
  localparam int unsigned NUM_GEN = 16;
  localparam int unsigned NUM_BANKED = 8;
  localparam int unsigned NUM_FLT = 16;
  localparam logic [3:0] INDEX_REG_NUM = 4'h0; // Index-capable register number
  localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] SR_RESET_VAL = 32'h7000_00f0; // Privileged, bank one, masked
  localparam int unsigned SR_BANK_BIT = 29;   // Bank-select bit position
  localparam int unsigned SR_MODE_BIT = 30;   // Privileged-mode bit position
  localparam logic [31:0] SR_PRIV_MASK = 32'h7000_0000; // Bits only privileged code alters
  // Control and system register selector codes
  typedef enum logic [3:0] {
    BRF_CTL_SR = 4'h0,
    BRF_CTL_GBR = 4'h1,
    BRF_CTL_VBR = 4'h2,
    BRF_CTL_SSR = 4'h3,
    BRF_CTL_SPC = 4'h4,
    BRF_CTL_MAC_HIGH = 4'h5,
    BRF_CTL_MAC_LOW = 4'h6,
    BRF_CTL_PR = 4'h7,
    BRF_CTL_FLOAT_STATUS_CONTROL = 4'h8,
    BRF_CTL_FLOAT_COMM_WORD = 4'h9,
    BRF_CTL_BANK = 4'ha   // Inactive-bank register, low index bits pick it
  } brf_ctl_sel_t;
  localparam int unsigned NUM_CTL = 10;
endpackage : brf_pkg
`default_nettype wire

// File: logic/brf_top.sv
// Banked CPU register file with optional float registers
//
// Overview of operation
// - Register zero serves as index operand.
// - Registers zero-seven banked; user sees bank zero.
// - Privileged bank-select bit chooses active bank.
// - Inactive bank only via control transfers.
// - Float registers writable only in float variant.
// - All registers are 32 bits wide.
// - User mode cannot reach bank one copies.
`default_nettype none
module brf_top #(
  parameter bit FLOAT_EN = 1'b1  // Build the float variant
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Two general read ports
  input wire logic [3:0] rd_a_num_in,
  output logic [31:0] rd_a_data_out,
  input wire logic [3:0] rd_b_num_in,
  output logic [31:0] rd_b_data_out,
  // Index operand, always register zero of the active bank
  output logic [31:0] index_data_out,
  // General write port
  input wire logic wr_en_in,
  input wire logic [3:0] wr_num_in,
  input wire logic [31:0] wr_data_in,
  // Control and system register port
  input wire logic ctl_rd_en_in,
  input wire logic [3:0] ctl_rd_sel_in,
  input wire logic [2:0] ctl_rd_bank_idx_in,
  output logic [31:0] ctl_rd_data_out,
  input wire logic ctl_wr_en_in,
  input wire logic [3:0] ctl_wr_sel_in,
  input wire logic [2:0] ctl_wr_bank_idx_in,
  input wire logic [31:0] ctl_wr_data_in,
  output logic ctl_fault_out,      // Denied control access in the previous cycle
  // Float register port
  input wire logic [3:0] flt_rd_num_in,
  output logic [31:0] flt_rd_data_out,
  input wire logic flt_wr_en_in,
  input wire logic [3:0] flt_wr_num_in,
  input wire logic [31:0] flt_wr_data_in,
  // Status view for the pipeline
  output logic priv_out,
  output logic bank_sel_out
);
  // Storage; each entry a full word
  // All storage is plain flip-flops indexed by register number, so reads
  // are a mux tree and never wait on a memory macro's read latency.
  // Bank zero copies of registers zero to seven
  logic [31:0] bank_zero_r [brf_pkg::NUM_BANKED];
  // Bank one copies of registers zero to seven
  logic [31:0] bank_one_r [brf_pkg::NUM_BANKED];
  logic [31:0] upper_r [brf_pkg::NUM_BANKED]; // Shared set
  // Control and system words, indexed by selector code
  logic [31:0] ctl_r [brf_pkg::NUM_CTL];
  // Float registers, kept even when the variant is off, but never written then
  logic [31:0] flt_r [brf_pkg::NUM_FLT];
  // Control read data is registered so the pipeline sees it one cycle later
  logic [31:0] ctl_rd_data_r;
  // One-cycle pulse after a refused control access
  logic ctl_fault_r;

  // Mode and bank select are decoded straight from the stored status word;
  // a status write therefore changes the visible bank on the next cycle.

  wire logic [31:0] status_word = ctl_r[brf_pkg::BRF_CTL_SR];
  wire logic priv = status_word[brf_pkg::SR_MODE_BIT];
  wire logic bank_sel_bit = status_word[brf_pkg::SR_BANK_BIT];
  wire logic active_bank;
  wire logic inactive_bank;
  wire logic inactive_ok;
  wire logic wr_banked;

  brf_bank_map u_map (
    .priv_in(priv),
    .bank_sel_in(bank_sel_bit),
    .gen_num_in(wr_num_in),
    .is_banked_out(wr_banked),
    .active_bank_out(active_bank),
    .inactive_bank_out(inactive_bank),
    .inactive_ok_out(inactive_ok)
  );

  // Read one general register through the active bank only
  // The inactive bank is deliberately not a choice here: only the control
  // port may reach it, which keeps ordinary operands from leaking across.
  function automatic logic [31:0] gen_read(input logic [3:0] num, input logic bank,
                                           input logic [31:0] b0 [8],
                                           input logic [31:0] b1 [8],
                                           input logic [31:0] up [8]);
    logic [2:0] idx;
    idx = num[2:0];
    if (num[3]) begin
      gen_read = up[idx];
    end else if (bank) begin
      gen_read = b1[idx];
    end else begin
      gen_read = b0[idx];
    end
  endfunction

  // Control selectors that only privileged code may touch
  function automatic logic ctl_is_priv(input logic [3:0] sel);
    ctl_is_priv = (sel == brf_pkg::BRF_CTL_SSR) || (sel == brf_pkg::BRF_CTL_SPC) ||
                  (sel == brf_pkg::BRF_CTL_VBR) || (sel == brf_pkg::BRF_CTL_BANK);
  endfunction

  // Float selectors vanish when the variant is not built
  function automatic logic ctl_is_flt(input logic [3:0] sel);
    ctl_is_flt = (sel == brf_pkg::BRF_CTL_FLOAT_STATUS_CONTROL) || (sel == brf_pkg::BRF_CTL_FLOAT_COMM_WORD);
  endfunction

  function automatic logic ctl_valid(input logic [3:0] sel, input logic p, input logic f);
    ctl_valid = (sel <= brf_pkg::BRF_CTL_BANK) && (p || !ctl_is_priv(sel)) &&
                (f || !ctl_is_flt(sel));
  endfunction

  // Ordinary operands never see the inactive bank
  assign rd_a_data_out = gen_read(rd_a_num_in, active_bank, bank_zero_r, bank_one_r, upper_r);
  assign rd_b_data_out = gen_read(rd_b_num_in, active_bank, bank_zero_r, bank_one_r, upper_r);
  // Index operand is a dedicated tap on register zero
  assign index_data_out = gen_read(brf_pkg::INDEX_REG_NUM, active_bank, bank_zero_r, bank_one_r,
                                   upper_r);

  // Control access decode
  // Read and write sides decode separately so a read and a write to
  // different selectors may share one cycle.
  wire logic ctl_rd_ok = ctl_valid(ctl_rd_sel_in, inactive_ok, FLOAT_EN);
  wire logic ctl_wr_ok = ctl_valid(ctl_wr_sel_in, inactive_ok, FLOAT_EN);
  wire logic ctl_rd_bank = (ctl_rd_sel_in == brf_pkg::BRF_CTL_BANK);
  wire logic ctl_wr_bank = (ctl_wr_sel_in == brf_pkg::BRF_CTL_BANK);
  wire logic [31:0] inact_rd_word = inactive_bank ? bank_one_r[ctl_rd_bank_idx_in] :
                                    bank_zero_r[ctl_rd_bank_idx_in];
  wire logic [31:0] ctl_rd_word = ctl_rd_bank ? inact_rd_word :
                                  ctl_r[ctl_rd_sel_in];
  wire logic ctl_fault_nxt = (ctl_rd_en_in && !ctl_rd_ok) || (ctl_wr_en_in && !ctl_wr_ok);
  // User code cannot alter mode or bank-select bits of the status word
  wire logic [31:0] sr_wr_word = priv ? ctl_wr_data_in :
                    ((ctl_wr_data_in & ~brf_pkg::SR_PRIV_MASK) |
                     (status_word & brf_pkg::SR_PRIV_MASK));
  wire logic gen_wr_lo = wr_en_in && wr_banked;
  wire logic ctl_wr_do = ctl_wr_en_in && ctl_wr_ok;

  // Banked lower registers; general writes to active bank, control writes to inactive
  // Both write sources may fire together; they cannot meet on one copy
  // because one aims at the active bank and the other at the inactive one.
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < brf_pkg::NUM_BANKED; i++) begin
      if (!rst_n_in) begin
        bank_zero_r[i] <= brf_pkg::REG_RESET_VAL;
        bank_one_r[i] <= brf_pkg::REG_RESET_VAL;
      end else begin
        if (gen_wr_lo && wr_num_in[2:0] == 3'(i) && !active_bank) begin
          bank_zero_r[i] <= wr_data_in;
        end else if (ctl_wr_do && ctl_wr_bank && ctl_wr_bank_idx_in == 3'(i) &&
                     !inactive_bank) begin
          bank_zero_r[i] <= ctl_wr_data_in;
        end
        if (gen_wr_lo && wr_num_in[2:0] == 3'(i) && active_bank) begin
          bank_one_r[i] <= wr_data_in;
        end else if (ctl_wr_do && ctl_wr_bank && ctl_wr_bank_idx_in == 3'(i) &&
                     inactive_bank) begin
          bank_one_r[i] <= ctl_wr_data_in;
        end
      end
    end
  end

  // Upper registers: one set for both modes and banks
  // Mode and bank select play no part here by design
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < brf_pkg::NUM_BANKED; i++) begin
      if (!rst_n_in) begin
        upper_r[i] <= brf_pkg::REG_RESET_VAL;
      end else if (wr_en_in && !wr_banked && wr_num_in[2:0] == 3'(i)) begin
        upper_r[i] <= wr_data_in;
      end
    end
  end

  // Control and system registers
  // Entry zero is the status word, with masked user writes; the inactive
  // bank selector never lands here, it is routed to the banked copies.
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < brf_pkg::NUM_CTL; i++) begin
      if (!rst_n_in) begin
        ctl_r[i] <= (i == 0) ? brf_pkg::SR_RESET_VAL : brf_pkg::REG_RESET_VAL;
      end else if (ctl_wr_do && !ctl_wr_bank && ctl_wr_sel_in == 4'(i)) begin
        ctl_r[i] <= (i == 0) ? sr_wr_word : ctl_wr_data_in;
      end
    end
  end

  // Float registers; held at reset value when the variant is absent
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < brf_pkg::NUM_FLT; i++) begin
      if (!rst_n_in) begin
        flt_r[i] <= brf_pkg::REG_RESET_VAL;
      end else if (FLOAT_EN && flt_wr_en_in && flt_wr_num_in == 4'(i)) begin
        flt_r[i] <= flt_wr_data_in;
      end
    end
  end
  assign flt_rd_data_out = FLOAT_EN ? flt_r[flt_rd_num_in] : brf_pkg::REG_RESET_VAL;

  // Registered control read data and fault flag; denied reads return zero
  // Returning zero on a refusal avoids exposing a sealed register's contents
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctl_rd_data_r <= brf_pkg::REG_RESET_VAL;
      ctl_fault_r <= 1'b0;
    end else begin
      ctl_rd_data_r <= (ctl_rd_en_in && ctl_rd_ok) ? ctl_rd_word : brf_pkg::REG_RESET_VAL;
      ctl_fault_r <= ctl_fault_nxt;
    end
  end
  assign ctl_rd_data_out = ctl_rd_data_r;
  assign ctl_fault_out = ctl_fault_r;
  assign priv_out = priv;
  assign bank_sel_out = bank_sel_bit;
endmodule // brf_top
`default_nettype wire

// File: tb/brf_ctl_issuer.sv
// Pipeline model issuing control register transfers
`default_nettype none
module brf_ctl_issuer (
  input wire logic sys_clk_in,
  output logic rd_en_out,
  output logic wr_en_out,
  output logic [3:0] sel_out,
  output logic [2:0] idx_out,
  output logic [31:0] data_out,
  input wire logic [31:0] rdata_in,
  input wire logic fault_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rd_en_out, wr_en_out, sel_out, idx_out, data_out} = '0;
  // One transfer, held from a falling edge across the taking edge
  task automatic xfer(input logic wr, input logic [3:0] sel, input logic [2:0] idx,
                      input logic [31:0] d, output logic [31:0] q, output logic f);
    repeat ($urandom % 2) @(negedge sys_clk_in); // Sometimes issue late
    {rd_en_out, wr_en_out, sel_out, idx_out, data_out} = {!wr, wr, sel, idx, d};
    @(negedge sys_clk_in);
    q = rdata_in;
    f = fault_in;
    {rd_en_out, wr_en_out} = 2'b00;
    @(negedge sys_clk_in); // Idle edge so strobes never toggle twice in one step
  endtask
endmodule // brf_ctl_issuer
`default_nettype wire

// File: tb/brf_top_monitor.sv
// Checker of the banked register file port behaviour
`default_nettype none
module brf_top_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] rd_a_num_in,
  input wire logic [31:0] rd_a_data_out,
  input wire logic [31:0] index_data_out,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_num_in,
  input wire logic [31:0] wr_data_in,
  input wire logic ctl_rd_en_in,
  input wire logic [3:0] ctl_rd_sel_in,
  input wire logic [31:0] ctl_rd_data_out,
  input wire logic ctl_wr_en_in,
  input wire logic [3:0] ctl_wr_sel_in,
  input wire logic [31:0] ctl_wr_data_in,
  input wire logic ctl_fault_out,
  input wire logic priv_out,
  input wire logic bank_sel_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_index_reg_zero: assert property (rd_a_num_in == 4'h0 |-> index_data_out == rd_a_data_out)
    else $error("index operand differs from register zero");
  a_write_read_back: assert property (wr_en_in && !ctl_wr_en_in && rd_a_num_in == wr_num_in |=>
    rd_a_data_out == $past(wr_data_in)) else $error("written word not read back");
  a_user_bank_fault: assert property (!priv_out && ctl_rd_en_in && ctl_rd_sel_in == 4'ha |=>
    ctl_fault_out && ctl_rd_data_out == 32'h0) else $error("user reached the other bank");
  a_user_priv_write: assert property (!priv_out && ctl_wr_en_in && ctl_wr_sel_in inside {[2:4]}
    |=> ctl_fault_out) else $error("user write to privileged register allowed");
  a_bad_sel_fault: assert property (ctl_rd_en_in && ctl_rd_sel_in > 4'ha |=> ctl_fault_out)
    else $error("unknown selector not refused");
  a_fault_has_cause: assert property (ctl_fault_out |-> $past(ctl_rd_en_in || ctl_wr_en_in))
    else $error("fault without a control access");
  a_priv_bank_pick: assert property (priv_out && ctl_wr_en_in && ctl_wr_sel_in == 4'h0 |=>
    bank_sel_out == $past(ctl_wr_data_in[29])) else $error("bank select not taken");
  a_user_mode_locked: assert property (!priv_out && ctl_wr_en_in && ctl_wr_sel_in == 4'h0 |=>
    !priv_out && $stable(bank_sel_out)) else $error("user changed mode or bank");
endmodule // brf_top_monitor
bind brf_top brf_top_monitor brf_top_monitor_i (.*);
`default_nettype wire

// File: tb/brf_top_tb_top.sv
// Testbench for the banked register file
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module brf_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n, wr_en, flt_wr_en, cf, cre, cwe, mode_p, mode_rb, priv, rbs, flt;
  logic [3:0] rd_a, rd_b, wr_num, flt_rd, flt_wn, csel;
  logic [2:0] cidx;
  logic [31:0] wr_data, flt_wd, cwd, crd, ra, rb, ix, fr, cq, d, b0 [8], b1 [8], up [8], fl [16];
  int fail_count = 0, n_compared = 0, cycles = 0;
  always #50 clk = ~clk;
  brf_top #(.FLOAT_EN(1'b1)) brf_top_i (.sys_clk_in(clk), .rst_n_in(rst_n),
    .rd_a_num_in(rd_a), .rd_a_data_out(ra), .rd_b_num_in(rd_b), .rd_b_data_out(rb),
    .index_data_out(ix), .wr_en_in(wr_en), .wr_num_in(wr_num), .wr_data_in(wr_data),
    .ctl_rd_en_in(cre), .ctl_rd_sel_in(csel), .ctl_rd_bank_idx_in(cidx), .ctl_rd_data_out(crd),
    .ctl_wr_en_in(cwe), .ctl_wr_sel_in(csel), .ctl_wr_bank_idx_in(cidx), .ctl_wr_data_in(cwd),
    .ctl_fault_out(flt), .flt_rd_num_in(flt_rd), .flt_rd_data_out(fr), .flt_wr_en_in(flt_wr_en),
    .flt_wr_num_in(flt_wn), .flt_wr_data_in(flt_wd), .priv_out(priv), .bank_sel_out(rbs));
  brf_ctl_issuer brf_ctl_issuer_i (.sys_clk_in(clk), .rd_en_out(cre), .wr_en_out(cwe),
    .sel_out(csel), .idx_out(cidx), .data_out(cwd), .rdata_in(crd), .fault_in(flt));
  // Word an ordinary operand should see in the current mode
  function automatic logic [31:0] exp_gen(input logic [3:0] n);
    if (n[3]) return up[n[2:0]];
    return (mode_p && mode_rb) ? b1[n[2:0]] : b0[n[2:0]];
  endfunction
  task automatic gw(input logic [3:0] n, input logic [31:0] v);
    {wr_en, wr_num, wr_data} = {1'b1, n, v};
    @(negedge clk);
    wr_en = 1'b0;
    if (n[3]) up[n[2:0]] = v;
    else if (mode_p && mode_rb) b1[n[2:0]] = v;
    else b0[n[2:0]] = v;
    @(negedge clk);
  endtask
  task automatic ctl(input logic w, input logic [3:0] s, input logic [2:0] i, input logic [31:0] v);
    brf_ctl_issuer_i.xfer(w, s, i, v, cq, cf);
  endtask
  // Every operand against the model, both read ports and the index path
  task automatic check_all();
    for (int n = 0; n < 16; n++) begin
      {rd_a, rd_b} = {n[3:0], 4'hf - n[3:0]};
      #10;
      `CHK(ra, exp_gen(rd_a))
      `CHK(rb, exp_gen(rd_b))
      `CHK(ix, exp_gen(4'h0))
      @(negedge clk);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {rst_n, wr_en, flt_wr_en, rd_a, rd_b, wr_num, wr_data, flt_rd, flt_wn, flt_wd} = '0;
    void'($urandom(35026));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK({priv, rbs}, 2'b11)
    {mode_p, mode_rb} = 2'b11;
    for (int i = 0; i < 16; i++) gw(i[3:0], $urandom);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      ctl(1'b1, 4'ha, i[2:0], d);
      b0[i] = d;
    end
    check_all();
    for (int i = 0; i < 8; i++) begin
      ctl(1'b0, 4'ha, i[2:0], 32'h0);
      `CHK(cq, b0[i])
    end
    ctl(1'b1, 4'h0, 3'h0, 32'h5000_00f0);
    mode_rb = 1'b0;
    `CHK(rbs, 1'b0)
    check_all();
    for (int i = 0; i < 8; i++) begin
      ctl(1'b0, 4'ha, i[2:0], 32'h0);
      `CHK(cq, b1[i])
    end
    d = $urandom;
    ctl(1'b1, 4'h2, 3'h0, d);
    ctl(1'b0, 4'h2, 3'h0, 32'h0);
    `CHK(cq, d)
    for (int s = 11; s < 16; s++) begin
      ctl(1'b0, s[3:0], 3'h0, 32'h0);
      `CHK({cf, cq}, {1'b1, 32'h0})
    end
    for (int i = 0; i < 16; i++) begin
      fl[i] = $urandom;
      {flt_wr_en, flt_wn, flt_wd} = {1'b1, i[3:0], fl[i]};
      @(negedge clk);
    end
    flt_wr_en = 1'b0;
    for (int i = 0; i < 16; i++) begin
      flt_rd = i[3:0];
      @(negedge clk);
      `CHK(fr, fl[i])
    end
    ctl(1'b1, 4'h0, 3'h0, 32'h2000_00f0);
    {mode_p, mode_rb} = 2'b01;
    check_all();
    gw(4'h3, $urandom);
    ctl(1'b0, 4'ha, 3'h3, 32'h0);
    `CHK({cf, cq}, {1'b1, 32'h0})
    ctl(1'b1, 4'h3, 3'h0, 32'h1);
    `CHK(cf, 1'b1)
    ctl(1'b1, 4'h0, 3'h0, 32'h7000_00f0);
    `CHK(priv, 1'b0)
    check_all();
    stop_test();
  end
endmodule // brf_top_tb_top
`default_nettype wire
